// ### bench/ubs_host_model.sv
`timescale 1ns/1ns
module ubs_host_model (
  // Clock
  input wire logic core_clk,
  // Shared bus pins
  output logic latch_strobe = 1'b0,
  output logic chip_sel_n = 1'b1,
  output logic fetch_n = 1'b1,
  output logic store_n = 1'b1,
  output logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n
);
  logic drv = 1'b1;
  logic [7:0] hval = 8'h00;
  // Released bus shows the inverse of the last value so stale data never matches
  assign ad_in = !ad_oe_n ? ad_out : (drv ? hval : ~hval);
  task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    drv <= 1'b1;
    hval <= a;
    latch_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    drv <= wr;
    hval <= d;
    chip_sel_n <= 1'b0;
    fetch_n <= wr;
    store_n <= !wr;
    for (int i = 0; i < 8 && (wr || ad_oe_n); i++) @(posedge core_clk);
    q = ad_out;
    repeat (4) @(posedge core_clk);
    chip_sel_n <= 1'b1;
    fetch_n <= 1'b1;
    store_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ### bench/ubs_top_assertions.sv
`timescale 1ns/1ns
module ubs_top_assertions #(
  parameter int LAMP_CYCLES = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus strobes and drive enable
  input wire logic chip_sel_n,
  input wire logic fetch_n,
  input wire logic ad_oe_n,
  // Interrupt and events
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic [3:0] good_cell_start,
  input wire logic [3:0] timing_byte_seen,
  // Status pins
  input wire logic [3:0] receive_activity_lamp_n,
  input wire logic receive_timing_marker_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Low-streak length of lamp 0 and cycles since the last read strobe
  logic [31:0] lamp_cnt_reg;
  logic [3:0] rd_age_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_cnt_reg <= 32'h0;
      rd_age_reg <= 4'hf;
    end else begin
      if (good_cell_start[0]) lamp_cnt_reg <= 32'h0;
      else if (!receive_activity_lamp_n[0]) lamp_cnt_reg <= lamp_cnt_reg + 32'h1;
      if (!fetch_n && !chip_sel_n) rd_age_reg <= 4'h0;
      else if (rd_age_reg != 4'hf) rd_age_reg <= rd_age_reg + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_irq_level; irq_out == 1'b0; endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level driven high");
  property p_bus_release; (fetch_n || chip_sel_n) [*4] |-> ad_oe_n; endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus not released");
  property p_read_drive; (!fetch_n && !chip_sel_n) [*4] |-> !ad_oe_n; endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_lamp_start; good_cell_start != 4'h0 |=>
    (receive_activity_lamp_n & $past(good_cell_start)) == 4'h0; endproperty
  a_lamp_start: assert property (p_lamp_start) else $error("lamp not lit");
  property p_lamp_len; $rose(receive_activity_lamp_n[0]) |->
    lamp_cnt_reg == 32'(LAMP_CYCLES); endproperty
  a_lamp_len: assert property (p_lamp_len) else $error("lamp length wrong");
  property p_mark_cause; $fell(receive_timing_marker_n) |->
    $past(timing_byte_seen) != 4'h0; endproperty
  a_mark_cause: assert property (p_mark_cause) else $error("marker without byte");
  property p_irq_cause; $fell(irq_oe_n) |->
    $past(good_cell_start | timing_byte_seen) != 4'h0; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  property p_irq_hold; $rose(irq_oe_n) |-> rd_age_reg < 4'h8; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq freed without read");
endmodule
bind ubs_top ubs_top_assertions #(.LAMP_CYCLES(LAMP_CYCLES)) u_ubs_top_assertions (
  .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .fetch_n(fetch_n),
  .ad_oe_n(ad_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
  .good_cell_start(good_cell_start), .timing_byte_seen(timing_byte_seen),
  .receive_activity_lamp_n(receive_activity_lamp_n),
  .receive_timing_marker_n(receive_timing_marker_n));

// ### bench/ubs_top_bench.sv
`timescale 1ns/1ns
module ubs_top_bench;
  localparam int LAMP = 16;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic latch_strobe, chip_sel_n, fetch_n, store_n, ad_oe_n, irq_out, irq_oe_n, mark_n;
  logic [7:0] ad_in, ad_out, q;
  logic [3:0] gcs = 4'h0;
  logic [3:0] tbs = 4'h0;
  logic [3:0] lamp_n;
  int miscompares = 0;
  int compares = 0;
  int stat = 0;
  int mask, len, nl, nm;
  ubs_top #(.LAMP_CYCLES(LAMP)) u_ubs_top (.core_clk(core_clk), .reset_n(reset_n),
    .latch_strobe(latch_strobe), .chip_sel_n(chip_sel_n), .fetch_n(fetch_n),
    .store_n(store_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .good_cell_start(gcs), .timing_byte_seen(tbs),
    .receive_activity_lamp_n(lamp_n), .receive_timing_marker_n(mark_n));
  ubs_host_model u_ubs_host_model (.core_clk(core_clk), .latch_strobe(latch_strobe),
    .chip_sel_n(chip_sel_n), .fetch_n(fetch_n), .store_n(store_n), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm_s, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm_s, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, d);
    u_ubs_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [7:0] a, exp, input string nm_s);
    u_ubs_host_model.xfer(1'b0, a, 8'h00, q);
    chk(nm_s, q, exp);
  endtask
  // Pulse events, then count low cycles of one lamp and of the marker
  task automatic ev(input logic [3:0] g, t, input int p);
    nl = 0;
    nm = 0;
    gcs <= g;
    tbs <= t;
    @(posedge core_clk);
    gcs <= 4'h0;
    tbs <= 4'h0;
    stat = stat | {t, g};
    repeat (30) begin
      @(posedge core_clk);
      nl += int'(lamp_n[p] === 1'b0);
      nm += int'(mark_n === 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #25 core_clk = ~core_clk;
  // Reserved straps are board wiring outside this block, held at fixed levels
  // Tests need about 1200 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'h169b61f7));
    repeat (4) @(posedge core_clk);
    chk("reset", {ad_oe_n, irq_oe_n, irq_out, mark_n, lamp_n}, 8'hdf);
    reset_n <= 1'b1;
    @(posedge core_clk);
    mask = $urandom_range(255);
    w(ubs_pkg::REG_INT_MASK, 8'(mask));
    r(ubs_pkg::REG_INT_MASK, 8'(mask), "mask");
    w(ubs_pkg::REG_INT_STATUS, 8'hff);
    r(ubs_pkg::REG_INT_STATUS, 8'h00, "status");
    r(8'h7f, 8'h00, "unmapped");
    for (int p = 0; p < 4; p++) begin
      ev(4'(1 << p), 4'h0, p);
      chk("lamp", 8'(nl), 8'(LAMP));
      chk("irq", {7'h0, irq_oe_n}, {7'h0, (stat & mask) == 0});
    end
    for (int s = 0; s < 4; s++) begin
      len = $urandom_range(8);
      w(ubs_pkg::REG_MARK_SEL, 8'(s));
      w(ubs_pkg::REG_MARK_LEN, 8'(len));
      r(ubs_pkg::REG_MARK_SEL, 8'(s), "sel");
      for (int p = 0; p < 4; p++) begin
        ev(4'h0, 4'(1 << p), 0);
        chk("marker", 8'(nm), (p == s) ? ((len == 0) ? 8'h01 : 8'(len)) : 8'h00);
      end
    end
    r(ubs_pkg::REG_INT_STATUS, 8'(stat), "status");
    stat = 0;
    w(ubs_pkg::REG_INT_MASK, 8'h10);
    ev(4'h1, 4'h0, 0);
    chk("irq", {7'h0, irq_oe_n}, 8'h01);
    ev(4'h0, 4'h1, 0);
    chk("irq", {7'h0, irq_oe_n}, 8'h00);
    r(ubs_pkg::REG_INT_STATUS, 8'h11, "status");
    chk("irq", {7'h0, irq_oe_n}, 8'h01);
    // Reset in mid-run, lamps just lit and registers programmed
    gcs <= 4'hf;
    @(posedge core_clk);
    gcs <= 4'h0;
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("reset", {ad_oe_n, irq_oe_n, irq_out, mark_n, lamp_n}, 8'hdf);
    reset_n <= 1'b1;
    @(posedge core_clk);
    r(ubs_pkg::REG_INT_MASK, ubs_pkg::INT_MASK_RST, "mask");
    r(ubs_pkg::REG_MARK_SEL, {6'h00, ubs_pkg::MARK_SEL_RST}, "sel");
    conclude();
  end
endmodule

// ### inc/ubs_pkg.sv
// Functional notes
// - The register address is taken from the 8-bit shared bus when the asynchronous latch strobe falls.
// - Chip select must be low for every access, and holding it low all the time is accepted.
// - During a read the block drives the addressed register onto the shared bus.
// - Write data is committed when the store strobe or chip select first goes high again.
// - The open-drain interrupt pin is pulled low and stays low until the status register is read.
// - A mask register enables each interrupt source, and only enabled sources reach the pin.
// - The asynchronous active-low reset clears all control state at once.
// - Each port's activity lamp goes low for 2^23 clocks from the start of each good cell.
// - A received timing byte pulses the active-low timing marker for a programmed clock count.
// - Register 0x40 selects which port's timing bytes produce the timing marker.
package ubs_pkg;

  localparam int NUM_PORTS = 4;
  localparam int CNT_W = 24;
  localparam int LAMP_CYCLES_DFLT = 8388608;

  // Register offsets on the shared bus
  localparam logic [7:0] REG_INT_STATUS = 8'h01;
  localparam logic [7:0] REG_INT_MASK = 8'h02;
  localparam logic [7:0] REG_MARK_SEL = 8'h40;
  localparam logic [7:0] REG_MARK_LEN = 8'h41;

  // Field positions and reset values
  localparam int MARK_SEL_LSB = 0;
  localparam int STAT_CELL_LSB = 0;
  localparam int STAT_MARK_LSB = 4;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [1:0] MARK_SEL_RST = 2'h0;
  localparam logic [7:0] MARK_LEN_RST = 8'h01;

  typedef struct packed {
    logic latch;
    logic chip_sel_n;
    logic fetch_n;
    logic store_n;
    logic [7:0] ad;
  } ubs_bus_in_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic hold_n;
  } ubs_stretch_s;

  typedef struct packed {
    ubs_bus_in_s sync1;
    ubs_bus_in_s sync2;
    logic [7:0] ad_prev;
    logic latch_prev;
    logic rd_active;
    logic wr_active;
    logic [7:0] wr_data;
    logic [7:0] addr;
    logic [7:0] int_status;
    logic [7:0] int_mask;
    logic [1:0] mark_sel;
    logic [7:0] mark_len;
    logic [7:0] ad_out;
    logic ad_oe_n;
    logic irq_oe_n;
  } ubs_top_s;

endpackage

// ### verilog/ubs_stretch.sv
`timescale 1ns/1ns
// Holds an active-low output for len cycles after each fire pulse; a new fire restarts it.
module ubs_stretch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Trigger and length
  input wire logic fire,
  input wire logic [ubs_pkg::CNT_W-1:0] len,
  // Stretched output
  output logic hold_n
);

  ubs_pkg::ubs_stretch_s state_reg;
  ubs_pkg::ubs_stretch_s state_next;

  always_comb begin
    state_next = state_reg;
    if (fire) begin
      // Zero length would underflow, so treat it as one cycle
      state_next.cnt = (len == '0) ? '0 : len - 1'b1;
      state_next.hold_n = 1'b0;
    end else if (!state_reg.hold_n) begin
      if (state_reg.cnt == '0) begin
        state_next.hold_n = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{cnt: '0, hold_n: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign hold_n = state_reg.hold_n;

endmodule

// ### verilog/ubs_top.sv
`timescale 1ns/1ns
module ubs_top #(
  parameter int LAMP_CYCLES = ubs_pkg::LAMP_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Shared address/data bus, asynchronous to core_clk
  input wire logic latch_strobe,
  input wire logic chip_sel_n,
  input wire logic fetch_n,
  input wire logic store_n,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe_n,
  // Open-drain interrupt
  output logic irq_out,
  output logic irq_oe_n,
  // Events from receive logic, one-cycle pulses on core_clk
  input wire logic [ubs_pkg::NUM_PORTS-1:0] good_cell_start,
  input wire logic [ubs_pkg::NUM_PORTS-1:0] timing_byte_seen,
  // Status pins
  output logic [ubs_pkg::NUM_PORTS-1:0] receive_activity_lamp_n,
  output logic receive_timing_marker_n
);

  ubs_pkg::ubs_top_s state_reg;
  ubs_pkg::ubs_top_s state_next;
  ubs_pkg::ubs_bus_in_s pins;
  logic [ubs_pkg::NUM_PORTS-1:0] lamp_n;
  logic marker_n;
  logic marker_fire;

  assign pins = '{latch: latch_strobe, chip_sel_n: chip_sel_n, fetch_n: fetch_n,
                  store_n: store_n, ad: ad_in};

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, registers and interrupt

  logic rd_now;
  logic wr_now;
  logic [7:0] rd_value;
  logic [7:0] events;
  logic [7:0] clr;

  always_comb begin
    state_next = state_reg;
    // Async pins pass two flops before any logic looks at them
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.ad_prev = state_reg.sync2.ad;
    state_next.latch_prev = state_reg.sync2.latch;

    // Address taken from the value seen just before the strobe fell
    if (state_reg.latch_prev && !state_reg.sync2.latch) begin
      state_next.addr = state_reg.ad_prev;
    end

    // Chip select may simply stay low; access is framed by the strobes
    rd_now = !state_reg.sync2.chip_sel_n && !state_reg.sync2.fetch_n;
    wr_now = !state_reg.sync2.chip_sel_n && !state_reg.sync2.store_n
             && state_reg.sync2.fetch_n;
    state_next.rd_active = rd_now;
    state_next.wr_active = wr_now;

    // Keep the last data seen while the write is open; the end edge is late by sync
    if (wr_now) begin
      state_next.wr_data = state_reg.sync2.ad;
    end

    case (state_reg.addr)
      ubs_pkg::REG_INT_STATUS: rd_value = state_reg.int_status;
      ubs_pkg::REG_INT_MASK: rd_value = state_reg.int_mask;
      ubs_pkg::REG_MARK_SEL: rd_value = {6'h00, state_reg.mark_sel};
      ubs_pkg::REG_MARK_LEN: rd_value = state_reg.mark_len;
      default: rd_value = 8'h00;
    endcase

    // Drive only while fetch and select are low, else leave the bus to the host
    if (rd_now) begin
      state_next.ad_out = rd_value;
      state_next.ad_oe_n = 1'b0;
    end else begin
      state_next.ad_oe_n = 1'b1;
    end

    // Commit at the first release of store or select
    if (state_reg.wr_active && !wr_now) begin
      case (state_reg.addr)
        ubs_pkg::REG_INT_MASK: state_next.int_mask = state_reg.wr_data;
        ubs_pkg::REG_MARK_SEL: state_next.mark_sel = state_reg.wr_data[1:0];
        ubs_pkg::REG_MARK_LEN: state_next.mark_len = state_reg.wr_data;
        default: state_next.int_mask = state_reg.int_mask;
      endcase
    end

    // Status clears only the bits the host actually saw; a new event wins
    clr = 8'h00;
    if (state_reg.rd_active && !rd_now && state_reg.addr == ubs_pkg::REG_INT_STATUS) begin
      clr = state_reg.ad_out;
    end
    events = 8'h00;
    events[ubs_pkg::STAT_CELL_LSB +: ubs_pkg::NUM_PORTS] = good_cell_start;
    events[ubs_pkg::STAT_MARK_LSB +: ubs_pkg::NUM_PORTS] = timing_byte_seen;
    state_next.int_status = (state_reg.int_status & ~clr) | events;

    // Pin pulled low while any enabled bit is pending
    state_next.irq_oe_n = ~|(state_next.int_status & state_reg.int_mask);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // All control state to constants at once
      state_reg <= '0;
      state_reg.sync1.chip_sel_n <= 1'b1;
      state_reg.sync1.fetch_n <= 1'b1;
      state_reg.sync1.store_n <= 1'b1;
      state_reg.sync2.chip_sel_n <= 1'b1;
      state_reg.sync2.fetch_n <= 1'b1;
      state_reg.sync2.store_n <= 1'b1;
      state_reg.int_mask <= ubs_pkg::INT_MASK_RST;
      state_reg.mark_sel <= ubs_pkg::MARK_SEL_RST;
      state_reg.mark_len <= ubs_pkg::MARK_LEN_RST;
      state_reg.ad_oe_n <= 1'b1;
      state_reg.irq_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity lamps and timing marker

  genvar p;
  generate
    for (p = 0; p < ubs_pkg::NUM_PORTS; p++) begin : g_lamp
      ubs_stretch u_lamp (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .fire(good_cell_start[p]),
        .len(ubs_pkg::CNT_W'(LAMP_CYCLES)),
        .hold_n(lamp_n[p])
      );
    end
  endgenerate

  // Only the selected port's timing bytes fire the marker
  assign marker_fire = timing_byte_seen[state_reg.mark_sel];

  ubs_stretch u_marker (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fire(marker_fire),
    .len({16'h0000, state_reg.mark_len}),
    .hold_n(marker_n)
  );

  assign receive_activity_lamp_n = lamp_n;
  assign receive_timing_marker_n = marker_n;
  assign ad_out = state_reg.ad_out;
  assign ad_oe_n = state_reg.ad_oe_n;
  // Open drain: level always low, enable decides
  assign irq_out = 1'b0;
  assign irq_oe_n = state_reg.irq_oe_n;

endmodule
